// [uirx_pkg.sv]
// Purpose: Shared constants for the serial port with infrared mode and error logic
// Assumes: Wishbone classic slave, 32-bit data, word-aligned registers
// Notes: Offsets are byte addresses
package uirx_pkg;
  localparam logic [4:0] ADDR_MODE = 5'h00;
  localparam logic [4:0] ADDR_STATUS = 5'h04;
  localparam logic [4:0] ADDR_TXDATA = 5'h08;
  localparam logic [4:0] ADDR_RXDATA = 5'h0c;
  localparam logic [4:0] ADDR_BAUD = 5'h10;
  localparam logic [4:0] ADDR_IRQ_STAT = 5'h14;
  localparam logic [4:0] ADDR_IRQ_MASK = 5'h18;
  // Mode register fields
  localparam int MODE_PDSEL_LO = 1;
  localparam int MODE_STOP_BIT_COUNT_SELECT_BIT = 0;
  localparam int MODE_IFACE_LO = 8;
  localparam int MODE_ENABLE_BIT = 15;
  localparam logic [1:0] IFACE_IR = 2'h3;
  // Status register fields
  localparam int STAT_RXDA_BIT = 0;
  localparam int STAT_OERR_BIT = 1;
  localparam int STAT_FRAMING_ERROR_FLAG_BIT = 2;
  localparam int STAT_PARITY_ERROR_FLAG_BIT = 3;
  localparam int STAT_RIDLE_BIT = 4;
  localparam int STAT_RXSEL_LO = 6;
  localparam int STAT_TXFULL_BIT = 9;
  localparam int STAT_TXBRK_BIT = 11;
  // Interrupt status bits
  localparam int IRQ_RX_BIT = 0;
  localparam int IRQ_TX_BIT = 1;
  localparam int IRQ_ERR_BIT = 2;
  localparam int IRQ_W = 3;
  localparam int OVERSAMPLE = 16;
  localparam logic [15:0] BAUD_RESET = 16'h0040;
  localparam logic [15:0] MODE_RESET = 16'h0000;
endpackage

// [uirx_baud.sv]
// Purpose: Free running baud tick and 16x baud clock generator
// Assumes: Divisor is stable while the port is enabled
// Notes: Runs while enabled, independent of transmit activity
`timescale 1ns/1ps
module uirx_baud
  import uirx_pkg::*;
#(
  parameter int DIV_W = 16
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic enable_i,
  input wire logic [DIV_W-1:0] divisor_i,
  output logic tick16_o,
  output logic bclk_o
);
  logic [DIV_W-1:0] cnt_reg;
  logic bclk_reg;
  wire wrap = (cnt_reg >= divisor_i);

  always_ff @(posedge clk_i) begin
    if (rst_i || !enable_i) begin
      cnt_reg <= '0;
      bclk_reg <= 1'b0;
    end else begin
      cnt_reg <= wrap ? '0 : cnt_reg + 1'b1;
      if (wrap) begin
        bclk_reg <= ~bclk_reg;
      end
    end
  end

  assign tick16_o = enable_i && wrap && bclk_reg;
  assign bclk_o = bclk_reg;
endmodule

// [uirx_rx_fifo.sv]
// Purpose: Receive FIFO that stores each byte together with its own error bits
// Assumes: Writer checks full, reader checks empty
// Notes: Error bits travel with the data, so no byte borrows another's flags
`timescale 1ns/1ps
module uirx_rx_fifo #(
  parameter int W = 10,
  parameter int DEPTH = 4,
  parameter int AW = 2
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wr_i,
  input wire logic [W-1:0] wdata_i,
  input wire logic rd_i,
  output logic [W-1:0] rdata_o,
  output logic [AW:0] count_o,
  output logic empty_o,
  output logic full_o
);
  logic [W-1:0] mem [DEPTH];
  logic [AW-1:0] wp_reg;
  logic [AW-1:0] rp_reg;
  logic [AW:0] cnt_reg;
  wire do_wr = wr_i && !full_o;
  wire do_rd = rd_i && !empty_o;

  always_ff @(posedge clk_i) begin
    if (do_wr) begin
      mem[wp_reg] <= wdata_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wp_reg <= '0;
      rp_reg <= '0;
      cnt_reg <= '0;
    end else begin
      if (do_wr) begin
        wp_reg <= wp_reg + 1'b1;
      end
      if (do_rd) begin
        rp_reg <= rp_reg + 1'b1;
      end
      cnt_reg <= cnt_reg + {{AW{1'b0}}, do_wr} - {{AW{1'b0}}, do_rd};
    end
  end

  assign rdata_o = mem[rp_reg];
  assign count_o = cnt_reg;
  assign empty_o = (cnt_reg == '0);
  assign full_o = (cnt_reg == (AW+1)'(DEPTH));
endmodule

// [uirx_top.sv]
// Purpose: Serial port with infrared baud clock, receive FIFO error tracking and interrupts
// Assumes: Wishbone classic slave on clk_i at 125 MHz, synchronous active high reset
// Notes: Frame is 8 data bits, optional parity, one or two stop bits
// Summary of operation
// [RL1] Interface mode field 11 selects infrared mode with 16x baud clock output.
// [RL2] The 16x baud clock runs always in infrared mode, also idle and receiving.
// [RL3] Receive select 1x raises receive interrupt at FIFO three-quarters full or full.
// [RL4] Every queued byte keeps its own parity and framing error bits.
// [RL5] Every receive error raises the error interrupt at once, none lost.
// [RL6] Status register shows parity and framing errors of the byte at FIFO head.
// [RL7] Third and later erroneous bytes flag errors like the first two.
// [RL8] Status bit 0 shows that received data waits in the FIFO.
// [RL9] With two stop bits the second stop bit decides the framing error.
// [RL10] Back-to-back break requests each send a real break character.
//
// The implementer's own choices: the Wishbone slave port and the address map.
`timescale 1ns/1ps
module uirx_top
  import uirx_pkg::*;
#(
  parameter int FIFO_DEPTH = 4
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [4:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic rx_i,
  output logic tx_o,
  output logic bclk_o,
  output logic irq_o
);
  localparam int AW = $clog2(FIFO_DEPTH);
  typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP1, RX_STOP2} uirx_rx_e;
  typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP, TX_BREAK} uirx_tx_e;

  logic [15:0] mode_reg;
  logic [15:0] baud_reg;
  logic [1:0] rxsel_reg;
  logic oerr_reg;
  logic [IRQ_W-1:0] irq_stat_reg;
  logic [IRQ_W-1:0] irq_mask_reg;
  logic ack_reg;
  logic [31:0] rdat_reg;
  logic rx_s1_reg;
  logic rx_s2_reg;

  // Bus decode
  wire bus_req = wb_cyc_i && wb_stb_i && !ack_reg;
  wire bus_wr = bus_req && wb_we_i && wb_sel_i[0];
  wire bus_rd = bus_req && !wb_we_i;
  wire wr_mode = bus_wr && (wb_adr_i == ADDR_MODE);
  wire wr_stat = bus_wr && (wb_adr_i == ADDR_STATUS);
  wire wr_tx = bus_wr && (wb_adr_i == ADDR_TXDATA);
  wire wr_baud = bus_wr && (wb_adr_i == ADDR_BAUD);
  wire wr_mask = bus_wr && (wb_adr_i == ADDR_IRQ_MASK);
  wire rd_rx = bus_rd && (wb_adr_i == ADDR_RXDATA);
  wire rd_irq = bus_rd && (wb_adr_i == ADDR_IRQ_STAT);
  wire enable = mode_reg[MODE_ENABLE_BIT];
  wire ir_mode = (mode_reg[MODE_IFACE_LO +: 2] == IFACE_IR);
  wire two_stop = mode_reg[MODE_STOP_BIT_COUNT_SELECT_BIT];
  wire par_en = mode_reg[MODE_PDSEL_LO];
  wire par_odd = mode_reg[MODE_PDSEL_LO+1];

  // Baud generation runs whenever enabled, not gated by transmit
  logic tick;
  logic bclk_int;
  uirx_baud #(.DIV_W(16)) u_baud (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .enable_i(enable),
    .divisor_i(baud_reg),
    .tick16_o(tick),
    .bclk_o(bclk_int)
  );
  assign bclk_o = ir_mode && bclk_int; // [RL1] [RL2]

  // Receiver
  uirx_rx_e rx_state;
  logic [3:0] rx_ph;
  logic [2:0] rx_bit;
  logic [7:0] rx_sh;
  logic rx_parity_error_flag;
  logic rx_framing_error_flag;
  logic rx_push;
  wire mid = tick && (rx_ph == 4'(OVERSAMPLE/2 - 1));
  wire bit_end = tick && (rx_ph == 4'(OVERSAMPLE - 1));
  wire rx_in = rx_s2_reg;

  logic [9:0] fifo_rdata;
  logic [AW:0] fifo_count;
  logic fifo_empty;
  logic fifo_full;
  uirx_rx_fifo #(.W(10), .DEPTH(FIFO_DEPTH), .AW(AW)) u_fifo (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .wr_i(rx_push),
    .wdata_i({rx_parity_error_flag, rx_framing_error_flag, rx_sh}), // [RL4] [RL7]
    .rd_i(rd_rx),
    .rdata_o(fifo_rdata),
    .count_o(fifo_count),
    .empty_o(fifo_empty),
    .full_o(fifo_full)
  );

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rx_s1_reg <= 1'b1;
      rx_s2_reg <= 1'b1;
    end else begin
      rx_s1_reg <= rx_i;
      rx_s2_reg <= rx_s1_reg;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || !enable) begin
      rx_state <= RX_IDLE;
      rx_ph <= '0;
      rx_bit <= '0;
      rx_sh <= '0;
      rx_parity_error_flag <= 1'b0;
      rx_framing_error_flag <= 1'b0;
      rx_push <= 1'b0;
    end else begin
      rx_push <= 1'b0;
      if (tick) begin
        rx_ph <= rx_ph + 4'h1;
      end
      case (rx_state)
        RX_IDLE: begin
          rx_ph <= '0;
          if (!rx_in) begin
            rx_state <= RX_START;
          end
        end
        RX_START: begin
          if (mid && rx_in) begin
            rx_state <= RX_IDLE;
          end else if (bit_end) begin
            rx_state <= RX_DATA;
            rx_bit <= '0;
            rx_parity_error_flag <= par_odd;
          end
        end
        RX_DATA: begin
          if (mid) begin
            rx_sh <= {rx_in, rx_sh[7:1]};
            rx_parity_error_flag <= rx_parity_error_flag ^ rx_in;
          end
          if (bit_end) begin
            rx_bit <= rx_bit + 3'h1;
            if (rx_bit == 3'h7) begin
              rx_state <= par_en ? RX_PAR : RX_STOP1;
            end
          end
        end
        RX_PAR: begin
          if (mid) begin
            rx_parity_error_flag <= rx_parity_error_flag ^ rx_in;
          end
          if (bit_end) begin
            rx_state <= RX_STOP1;
          end
        end
        RX_STOP1: begin
          if (!par_en) begin
            rx_parity_error_flag <= 1'b0;
          end
          if (mid) begin
            rx_framing_error_flag <= !rx_in;
            if (!two_stop) begin
              rx_push <= 1'b1;
              rx_state <= RX_IDLE;
            end
          end
          if (bit_end && two_stop) begin
            rx_state <= RX_STOP2;
          end
        end
        RX_STOP2: begin
          if (mid) begin
            rx_framing_error_flag <= !rx_in; // [RL9]
            rx_push <= 1'b1;
            rx_state <= RX_IDLE;
          end
        end
        default: rx_state <= RX_IDLE;
      endcase
    end
  end

  // Transmitter with break support
  uirx_tx_e tx_state;
  logic [3:0] tx_ph;
  logic [3:0] tx_bit;
  logic [7:0] tx_sh;
  logic tx_par;
  logic tx_full_reg;
  logic [7:0] tx_hold_reg;
  logic brk_req_reg;
  logic tx_out_reg;
  wire tx_bit_end = tick && (tx_ph == 4'(OVERSAMPLE - 1));

  always_ff @(posedge clk_i) begin
    if (rst_i || !enable) begin
      tx_state <= TX_IDLE;
      tx_ph <= '0;
      tx_bit <= '0;
      tx_sh <= '0;
      tx_par <= 1'b0;
      tx_full_reg <= 1'b0;
      tx_hold_reg <= '0;
      brk_req_reg <= 1'b0;
      tx_out_reg <= 1'b1;
    end else begin
      if (wr_tx && !tx_full_reg) begin
        tx_hold_reg <= wb_dat_i[7:0];
        tx_full_reg <= 1'b1;
      end
      if (tick) begin
        tx_ph <= tx_ph + 4'h1;
      end
      case (tx_state)
        TX_IDLE: begin
          tx_out_reg <= 1'b1;
          tx_ph <= '0;
          // Start only on a tick so the first bit time is a whole one
          if (tick && tx_full_reg && brk_req_reg) begin
            // Dummy byte is consumed, break request cleared per character
            tx_full_reg <= 1'b0;
            brk_req_reg <= 1'b0; // [RL10]
            tx_bit <= '0;
            tx_state <= TX_BREAK;
          end else if (tick && tx_full_reg) begin
            tx_sh <= tx_hold_reg;
            tx_par <= par_odd;
            tx_full_reg <= 1'b0;
            tx_state <= TX_START;
          end
        end
        TX_START: begin
          tx_out_reg <= 1'b0;
          if (tx_bit_end) begin
            tx_bit <= '0;
            tx_state <= TX_DATA;
          end
        end
        TX_DATA: begin
          tx_out_reg <= tx_sh[0];
          if (tx_bit_end) begin
            tx_par <= tx_par ^ tx_sh[0];
            tx_sh <= {1'b0, tx_sh[7:1]};
            tx_bit <= tx_bit + 4'h1;
            if (tx_bit == 4'h7) begin
              tx_bit <= '0;
              tx_state <= par_en ? TX_PAR : TX_STOP;
            end
          end
        end
        TX_PAR: begin
          tx_out_reg <= tx_par;
          if (tx_bit_end) begin
            tx_state <= TX_STOP;
          end
        end
        TX_STOP: begin
          tx_out_reg <= 1'b1;
          if (tx_bit_end) begin
            tx_bit <= tx_bit + 4'h1;
            if (tx_bit == (two_stop ? 4'h1 : 4'h0)) begin
              tx_state <= TX_IDLE;
            end
          end
        end
        TX_BREAK: begin
          // Start plus 12 low bit times, then one stop bit
          tx_out_reg <= (tx_bit == 4'hd) ? 1'b1 : 1'b0;
          if (tx_bit_end) begin
            tx_bit <= tx_bit + 4'h1;
            if (tx_bit == 4'hd) begin
              tx_state <= TX_IDLE;
            end
          end
        end
        default: tx_state <= TX_IDLE;
      endcase
      // A new break request wins over the clear of the one being consumed
      if (wr_stat && wb_dat_i[STAT_TXBRK_BIT]) begin
        brk_req_reg <= 1'b1;
      end
    end
  end
  assign tx_o = tx_out_reg;

  // Receive interrupt threshold
  logic [AW:0] thresh;
  assign thresh = rxsel_reg[1]
      ? (rxsel_reg[0] ? (AW+1)'(FIFO_DEPTH) : (AW+1)'(FIFO_DEPTH*3/4)) // [RL3]
      : (AW+1)'(1);
  wire rx_level_hit = (fifo_count >= thresh);
  logic rx_hit_d;
  wire rx_event = rx_level_hit && !rx_hit_d;
  wire err_event = rx_push && (rx_parity_error_flag || rx_framing_error_flag || fifo_full);
  wire tx_event = (tx_state == TX_IDLE) && tx_full_reg && tick;
  wire [IRQ_W-1:0] ev = {err_event, tx_event, rx_event};

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mode_reg <= MODE_RESET;
      baud_reg <= BAUD_RESET;
      rxsel_reg <= '0;
      oerr_reg <= 1'b0;
      irq_stat_reg <= '0;
      irq_mask_reg <= '0;
      rx_hit_d <= 1'b0;
    end else begin
      rx_hit_d <= rx_level_hit;
      if (wr_mode) begin
        mode_reg <= wb_dat_i[15:0];
      end
      if (wr_baud) begin
        baud_reg <= wb_dat_i[15:0];
      end
      if (wr_stat) begin
        rxsel_reg <= wb_dat_i[STAT_RXSEL_LO +: 2];
      end
      if (rx_push && fifo_full) begin
        oerr_reg <= 1'b1;
      end else if (wr_stat && !wb_dat_i[STAT_OERR_BIT]) begin
        oerr_reg <= 1'b0;
      end
      // Events set, a read clears; set wins over the clear
      irq_stat_reg <= (rd_irq ? '0 : irq_stat_reg) | ev; // [RL5]
      if (wr_mask) begin
        irq_mask_reg <= wb_dat_i[IRQ_W-1:0];
      end
    end
  end

  // Read mux
  logic [31:0] stat_word;
  always_comb begin
    stat_word = '0;
    stat_word[STAT_RXDA_BIT] = !fifo_empty; // [RL8]
    stat_word[STAT_OERR_BIT] = oerr_reg;
    stat_word[STAT_FRAMING_ERROR_FLAG_BIT] = !fifo_empty && fifo_rdata[8]; // [RL6]
    stat_word[STAT_PARITY_ERROR_FLAG_BIT] = !fifo_empty && fifo_rdata[9]; // [RL6]
    stat_word[STAT_RIDLE_BIT] = (rx_state == RX_IDLE);
    stat_word[STAT_RXSEL_LO +: 2] = rxsel_reg;
    stat_word[STAT_TXFULL_BIT] = tx_full_reg;
    stat_word[STAT_TXBRK_BIT] = brk_req_reg;
  end
  wire [31:0] rd_word =
      (wb_adr_i == ADDR_MODE) ? {16'h0000, mode_reg} :
      (wb_adr_i == ADDR_STATUS) ? stat_word :
      (wb_adr_i == ADDR_RXDATA) ? {24'h000000, fifo_rdata[7:0]} :
      (wb_adr_i == ADDR_BAUD) ? {16'h0000, baud_reg} :
      (wb_adr_i == ADDR_IRQ_STAT) ? {{(32-IRQ_W){1'b0}}, irq_stat_reg} :
      (wb_adr_i == ADDR_IRQ_MASK) ? {{(32-IRQ_W){1'b0}}, irq_mask_reg} :
      32'h00000000;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_reg <= 1'b0;
      rdat_reg <= '0;
    end else begin
      ack_reg <= bus_req;
      if (bus_rd) begin
        rdat_reg <= rd_word;
      end
    end
  end
  assign wb_ack_o = ack_reg;
  assign wb_dat_o = rdat_reg;
  assign irq_o = |(irq_stat_reg & irq_mask_reg);
endmodule

// [uirx_checker.sv]
// Purpose: Port assertions for uirx_top
// Assumes: Mode writes use sel[0]
// Notes: ir_mode_reg follows mode writes at the edge the port takes them
`timescale 1ns/1ps
module uirx_checker
  import uirx_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [4:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic tx_o,
  input wire logic bclk_o,
  input wire logic irq_o
);
  logic ir_mode_reg;
  wire ir_next = wb_dat_i[MODE_ENABLE_BIT] && wb_dat_i[MODE_IFACE_LO+:2] == IFACE_IR;
  wire req_new = wb_cyc_i && wb_stb_i && !wb_ack_o;
  wire mode_wr = req_new && wb_we_i && wb_adr_i == ADDR_MODE && wb_sel_i[0];
  wire irq_clr = wb_ack_o && (wb_adr_i == ADDR_IRQ_STAT && !wb_we_i ||
    wb_adr_i == ADDR_IRQ_MASK && wb_we_i);
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ir_mode_reg <= 1'b0;
    end else if (mode_wr) begin
      ir_mode_reg <= ir_next;
    end
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  chk_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  chk_ack_latency: assert property (req_new |=> wb_ack_o)
    else $error("ack late");
  chk_ack_cause: assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  chk_unmapped_zero: assert property (req_new && !wb_we_i && wb_adr_i > ADDR_IRQ_MASK
    |=> wb_dat_o == 32'h0)
    else $error("unmapped read not zero");
  chk_reset_outputs: assert property ($fell(rst_i) |-> tx_o && !bclk_o && !irq_o)
    else $error("outputs wrong after reset");
  chk_irq_drop: assert property ($fell(irq_o) |-> irq_clr)
    else $error("irq dropped without clear");
  chk_ir_clock: assert property (ir_mode_reg |-> ##[1:300] $changed(bclk_o))
    else $error("baud clock stopped");
  chk_bclk_off: assert property ((!ir_mode_reg)[*3] |-> !bclk_o)
    else $error("baud clock outside infrared mode");
endmodule
bind uirx_top uirx_checker i_uirx_checker(.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
  .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .tx_o(tx_o),
  .bclk_o(bclk_o), .irq_o(irq_o));

// [uirx_remote.sv]
// Purpose: Remote serial device on rx and tx lines
// Assumes: BIT clock cycles per bit, 8 data bits, even parity
// Notes: Line idles high
`timescale 1ns/1ps
module uirx_remote #(
  parameter int BIT = 64
) (
  input wire logic clk_i,
  input wire logic tx_i,
  output logic rx_o
);
  initial rx_o = 1'b1;
  task automatic put(input logic v);
    rx_o <= v;
    repeat (BIT) @(posedge clk_i);
  endtask
  task automatic send(input logic [7:0] b, input logic bad_par, input logic two,
    input logic bad_stop);
    put(1'b0);
    for (int i = 0; i < 8; i++) put(b[i]);
    put(^b ^ bad_par);
    if (two) put(1'b1);
    if (bad_stop) begin
      // Low only past the sampling point, so the tail is not taken for a start bit
      rx_o <= 1'b0;
      repeat (BIT * 3 / 4) @(posedge clk_i);
      rx_o <= 1'b1;
      repeat (BIT / 4) @(posedge clk_i);
    end else begin
      put(1'b1);
    end
    put(1'b1);
    put(1'b1);
  endtask
  // Counts the cycles of the next low stretch on tx
  task automatic low_run(output int n);
    n = 0;
    while (tx_i !== 1'b0) @(posedge clk_i);
    while (tx_i === 1'b0) begin
      n++;
      @(posedge clk_i);
    end
  endtask
endmodule

// [uirx_top_tb.sv]
// Purpose: Self-checking bench for uirx_top
// Assumes: Baud divisor 1, so a bit lasts 64 cycles
// Notes: One task per scenario
`timescale 1ns/1ps
module uirx_top_tb;
  import uirx_pkg::*;
  localparam int BIT = 64;
  localparam logic [31:0] MODE_IR = 32'h8302;
  localparam logic [1:0] EP [4] = '{2'b10, 2'b01, 2'b10, 2'b00};
  localparam logic [31:0] EI [4] = '{32'h4, 32'h4, 32'h5, 32'h0};
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [4:0] wb_adr_i = 5'h00;
  logic [3:0] wb_sel_i = 4'hf;
  logic [31:0] wb_dat_i = 32'h0;
  logic [31:0] wb_dat_o, q;
  logic wb_ack_o, rx_i, tx_o, bclk_o, irq_o;
  int miscompares = 0;
  int comparisons = 0;
  initial begin
    forever #4 clk_i = ~clk_i;
  end
  uirx_top #(.FIFO_DEPTH(4)) i_uirx_top(.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .rx_i(rx_i),
    .tx_o(tx_o), .bclk_o(bclk_o), .irq_o(irq_o));
  uirx_remote #(.BIT(BIT)) i_uirx_remote(.clk_i(clk_i), .tx_i(tx_o), .rx_o(rx_i));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    comparisons++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic end_of_test;
    if (miscompares == 0 && comparisons > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic wb(input logic we, input logic [4:0] a, input logic [31:0] d);
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    @(posedge clk_i);
    while (wb_ack_o !== 1'b1) @(posedge clk_i);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask
  task automatic edges(output int n);
    logic last;
    n = 0;
    last = bclk_o;
    repeat (2 * BIT) begin
      @(posedge clk_i);
      n += int'(bclk_o !== last);
      last = bclk_o;
    end
  endtask
  task automatic t_reset;
    wb(1'b0, ADDR_MODE, 32'h0);
    chk(q, {16'h0, MODE_RESET}, "mode");
    wb(1'b0, ADDR_BAUD, 32'h0);
    chk(q, {16'h0, BAUD_RESET}, "baud");
    wb(1'b0, 5'h1c, 32'h0);
    chk(q, 32'h0, "unmapped");
  endtask
  // 16x clock at 64 cycles a bit toggles every 2 cycles
  task automatic t_irclk;
    int n;
    wb(1'b1, ADDR_BAUD, 32'h1);
    wb(1'b1, ADDR_MODE, 32'h8002);
    edges(n);
    chk(n, 32'h0, "bclk plain mode");
    wb(1'b1, ADDR_MODE, MODE_IR);
    edges(n);
    chk(32'(n > 62 && n < 66), 32'h1, "bclk idle");
    fork
      i_uirx_remote.send(8'h3c, 1'b0, 1'b0, 1'b0);
      edges(n);
    join
    chk(32'(n > 62 && n < 66), 32'h1, "bclk receiving");
    wb(1'b0, ADDR_RXDATA, 32'h0);
    chk(q & 32'hff, 32'h3c, "rx byte");
  endtask
  task automatic t_err;
    wb(1'b0, ADDR_IRQ_STAT, 32'h0);
    wb(1'b1, ADDR_STATUS, 32'h0080);
    wb(1'b1, ADDR_IRQ_MASK, 32'h4);
    for (int i = 0; i < 4; i++) begin
      i_uirx_remote.send(8'(8'ha0 + i), EP[i][1], 1'b0, EP[i][0]);
      chk(32'(irq_o), 32'(EP[i] != 2'b00), "error irq");
      wb(1'b0, ADDR_IRQ_STAT, 32'h0);
      chk(q, EI[i], "irq status");
      chk(32'(irq_o), 32'h0, "irq cleared");
    end
    for (int i = 0; i < 4; i++) begin
      wb(1'b0, ADDR_STATUS, 32'h0);
      chk(q & 32'hf, {28'h0, EP[i], 2'b01}, "status flags");
      wb(1'b0, ADDR_RXDATA, 32'h0);
      chk(q & 32'hff, 32'ha0 + i, "rx data");
    end
    wb(1'b0, ADDR_STATUS, 32'h0);
    chk(q & 32'h1, 32'h0, "data available");
  endtask
  task automatic t_stop2;
    wb(1'b1, ADDR_MODE, MODE_IR | 32'h1);
    i_uirx_remote.send(8'h5a, 1'b0, 1'b1, 1'b1);
    i_uirx_remote.send(8'h5b, 1'b0, 1'b1, 1'b0);
    wb(1'b0, ADDR_STATUS, 32'h0);
    chk(q & 32'hf, 32'h5, "second stop low");
    wb(1'b0, ADDR_RXDATA, 32'h0);
    wb(1'b0, ADDR_STATUS, 32'h0);
    chk(q & 32'hf, 32'h1, "second stop high");
    wb(1'b0, ADDR_RXDATA, 32'h0);
  endtask
  task automatic t_break;
    int n;
    fork
      begin
        repeat (2) begin
          // Wait until the previous break request has been taken
          do begin
            wb(1'b0, ADDR_STATUS, 32'h0);
          end while (q[STAT_TXBRK_BIT]);
          wb(1'b1, ADDR_STATUS, 32'h0800);
          wb(1'b1, ADDR_TXDATA, 32'h55);
        end
      end
      repeat (2) begin
        i_uirx_remote.low_run(n);
        chk(n, 13 * BIT, "break length");
      end
    join
  endtask
  initial begin
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset;
    t_irclk;
    t_err;
    t_stop2;
    t_break;
    end_of_test;
  end
  initial begin
    repeat (30000) @(posedge clk_i);
    miscompares++;
    end_of_test;
  end
endmodule
